//--- src/sat_arith_pkg.sv
// package: operation codes and constants for the saturating arithmetic unit
package sat_arith_pkg;
	localparam int unsigned DATA_WIDTH = 32;
	localparam int unsigned HALF_WIDTH = 16;
	localparam int unsigned BYTE_WIDTH = 8;
	localparam logic RESET_SAT_FLAG = 1'b0;
	localparam logic [31:0] SINT_MAX = 32'h7FFFFFFF;
	localparam logic [31:0] SINT_MIN = 32'h80000000;
	localparam logic [15:0] UHALF_MAX = 16'hFFFF;
	localparam logic [7:0] UBYTE_MAX = 8'hFF;

	typedef enum logic [3:0] {
		OP_NONE,
		OP_SAT_DOUBLE_ADD,
		OP_SAT_DOUBLE_SUB,
		OP_UNS_SAT_ADD_SUB_EXCHANGE,
		OP_UNS_SAT_SUB_ADD_EXCHANGE,
		OP_UNS_SAT_ADD_HALVES,
		OP_UNS_SAT_ADD_BYTES,
		OP_UNS_SAT_SUB_HALVES,
		OP_UNS_SAT_SUB_BYTES
	} sat_op_t;
endpackage : sat_arith_pkg

//--- src/saturating_arith_unit.sv
// saturating arithmetic datapath with the sticky saturation flag
`timescale 1ns/1ps
module saturating_arith_unit
	import sat_arith_pkg::*;
(
	// clock and reset
	input  wire logic                  sys_clk_in,
	input  wire logic                  rst_in,
	// operation request
	input  wire logic                  op_valid_in,
	input  sat_op_t                    op_sel_in,
	input  wire logic [DATA_WIDTH-1:0] first_operand_in,
	input  wire logic [DATA_WIDTH-1:0] second_operand_in,
	// status register access
	input  wire logic                  status_write_instr_in,
	input  wire logic                  status_write_q_in,
	// results
	output logic                       result_valid_out,
	output logic [DATA_WIDTH-1:0]      result_out,
	output logic                       cond_flags_we_out,
	output logic                       sat_flag_out
);
	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic                  valid;
		logic [DATA_WIDTH-1:0] result;
		logic                  sat;
	} state_t;

	state_t state;
	state_t next_state;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [31:0] sclamp(input logic signed [33:0] v, output logic hit);
		hit = 1'b0;
		if (v > $signed({2'b00, SINT_MAX})) begin
			hit = 1'b1;
			return SINT_MAX;
		end
		if (v < $signed({2'b11, SINT_MIN})) begin
			hit = 1'b1;
			return SINT_MIN;
		end
		return v[31:0];
	endfunction : sclamp

	// 17-bit unsigned lane value: bit 16 marks carry or borrow
	function automatic logic [15:0] uhalf(input logic [15:0] a, input logic [15:0] b,
		input logic sub);
		logic [16:0] r;
		r = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
		if (r[16]) begin
			return sub ? 16'h0000 : UHALF_MAX;
		end
		return r[15:0];
	endfunction : uhalf

	function automatic logic [7:0] ubyte(input logic [7:0] a, input logic [7:0] b,
		input logic sub);
		logic [8:0] r;
		r = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
		if (r[8]) begin
			return sub ? 8'h00 : UBYTE_MAX;
		end
		return r[7:0];
	endfunction : ubyte

	// ************************************************************
	// datapath
	// ************************************************************
	logic [15:0] a_hi;
	logic [15:0] a_lo;
	logic [15:0] b_hi;
	logic [15:0] b_lo;
	assign a_hi = first_operand_in[31:16];
	assign a_lo = first_operand_in[15:0];
	assign b_hi = second_operand_in[31:16];
	assign b_lo = second_operand_in[15:0];

	always_comb begin
		logic [31:0] dbl;
		logic [31:0] res;
		logic        hit_dbl;
		logic        hit_sum;
		dbl = '0;
		res = '0;
		hit_dbl = 1'b0;
		hit_sum = 1'b0;
		next_state = state;
		next_state.valid = op_valid_in && (op_sel_in != OP_NONE);
		dbl = sclamp({{2{second_operand_in[31]}}, second_operand_in} <<< 1, hit_dbl);
		unique case (op_sel_in)
			OP_SAT_DOUBLE_ADD: begin
				res = sclamp($signed({{2{first_operand_in[31]}}, first_operand_in})
					+ $signed({{2{dbl[31]}}, dbl}), hit_sum);
			end
			OP_SAT_DOUBLE_SUB: begin
				res = sclamp($signed({{2{first_operand_in[31]}}, first_operand_in})
					- $signed({{2{dbl[31]}}, dbl}), hit_sum);
			end
			OP_UNS_SAT_ADD_SUB_EXCHANGE: begin
				res = {uhalf(a_hi, b_lo, 1'b0), uhalf(a_lo, b_hi, 1'b1)};
			end
			OP_UNS_SAT_SUB_ADD_EXCHANGE: begin
				res = {uhalf(a_hi, b_lo, 1'b1), uhalf(a_lo, b_hi, 1'b0)};
			end
			OP_UNS_SAT_ADD_HALVES: begin
				res = {uhalf(a_hi, b_hi, 1'b0), uhalf(a_lo, b_lo, 1'b0)};
			end
			OP_UNS_SAT_SUB_HALVES: begin
				res = {uhalf(a_hi, b_hi, 1'b1), uhalf(a_lo, b_lo, 1'b1)};
			end
			OP_UNS_SAT_ADD_BYTES, OP_UNS_SAT_SUB_BYTES: begin
				for (int i = 0; i < 4; i++) begin
					res[i*8 +: 8] = ubyte(first_operand_in[i*8 +: 8],
						second_operand_in[i*8 +: 8],
						op_sel_in == OP_UNS_SAT_SUB_BYTES);
				end
			end
			default: begin
				res = '0;
			end
		endcase
		if (next_state.valid) begin
			next_state.result = res;
		end
		// set wins over an explicit clear in the same cycle
		if (status_write_instr_in) begin
			next_state.sat = status_write_q_in;
		end
		if (next_state.valid && (op_sel_in == OP_SAT_DOUBLE_ADD
			|| op_sel_in == OP_SAT_DOUBLE_SUB) && (hit_dbl || hit_sum)) begin
			next_state.sat = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= '{valid: 1'b0, result: '0, sat: RESET_SAT_FLAG};
		end else begin
			state <= next_state;
		end
	end

	assign result_valid_out = state.valid;
	assign result_out = state.result;
	assign sat_flag_out = state.sat;
	// no operation here produces condition codes
	assign cond_flags_we_out = 1'b0;

	// ************************************************************
	// checks
	// ************************************************************
	AST_BYTE_ADD_CLAMP: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		op_valid_in && op_sel_in == OP_UNS_SAT_ADD_BYTES
		&& ({1'b0, first_operand_in[7:0]} + {1'b0, second_operand_in[7:0]}) > 9'h0FF
		|=> result_out[7:0] == UBYTE_MAX)
		else $error("byte add lane did not clamp");
	AST_HALF_SUB_ZERO: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		op_valid_in && op_sel_in == OP_UNS_SAT_SUB_HALVES && a_hi < b_hi
		|=> result_out[31:16] == 16'h0000)
		else $error("halfword subtract lane did not clamp to zero");
	AST_DOUBLE_ADD_MAX: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		op_valid_in && op_sel_in == OP_SAT_DOUBLE_ADD && second_operand_in == SINT_MAX
		&& !first_operand_in[31] |=> result_out == SINT_MAX && sat_flag_out)
		else $error("double add did not saturate high");
	AST_DOUBLE_SUB_PLAIN: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		op_valid_in && op_sel_in == OP_SAT_DOUBLE_SUB && second_operand_in == 32'h00000001
		&& first_operand_in == 32'h00000010 |=> result_out == 32'h0000000E)
		else $error("double subtract wrong");
	AST_FLAG_STICKY: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		sat_flag_out && !status_write_instr_in |=> sat_flag_out)
		else $error("sticky flag lost");
	AST_FLAG_CLEAR: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!sat_flag_out && !(op_valid_in && (op_sel_in == OP_SAT_DOUBLE_ADD
		|| op_sel_in == OP_SAT_DOUBLE_SUB)) && !status_write_instr_in |=> !sat_flag_out)
		else $error("flag set without cause");
	AST_UNS_NO_FLAG: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		op_valid_in && op_sel_in == OP_UNS_SAT_ADD_HALVES && !status_write_instr_in
		|=> sat_flag_out == $past(sat_flag_out) && !cond_flags_we_out)
		else $error("unsigned op changed flags");
	AST_EXCH_TOP: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		op_valid_in && op_sel_in == OP_UNS_SAT_ADD_SUB_EXCHANGE
		&& ({1'b0, a_hi} + {1'b0, b_lo}) <= 17'h0FFFF
		|=> result_out[31:16] == $past(a_hi) + $past(b_lo))
		else $error("exchange top half wrong");
	AST_EXCH_BOT_ZERO: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		op_valid_in && op_sel_in == OP_UNS_SAT_ADD_SUB_EXCHANGE && a_lo < b_hi
		|=> result_out[15:0] == 16'h0000)
		else $error("exchange bottom half did not clamp to zero");
	AST_SUBX_TOP_ZERO: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		op_valid_in && op_sel_in == OP_UNS_SAT_SUB_ADD_EXCHANGE && a_hi < b_lo
		|=> result_out[31:16] == 16'h0000)
		else $error("sub-add exchange top half did not clamp to zero");
	AST_SUBX_BOT_SUM: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		op_valid_in && op_sel_in == OP_UNS_SAT_SUB_ADD_EXCHANGE
		&& ({1'b0, a_lo} + {1'b0, b_hi}) <= 17'h0FFFF
		|=> result_out[15:0] == $past(a_lo) + $past(b_hi))
		else $error("sub-add exchange bottom half wrong");
	AST_HALF_ADD_CLAMP: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		op_valid_in && op_sel_in == OP_UNS_SAT_ADD_HALVES
		&& ({1'b0, a_lo} + {1'b0, b_lo}) > 17'h0FFFF
		|=> result_out[15:0] == UHALF_MAX)
		else $error("halfword add lane did not clamp");
	AST_BYTE_SUB_ZERO: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		op_valid_in && op_sel_in == OP_UNS_SAT_SUB_BYTES
		&& first_operand_in[31:24] < second_operand_in[31:24]
		|=> result_out[31:24] == 8'h00)
		else $error("byte subtract lane did not clamp to zero");
	// a doubled minimum always clamps, so the flag must be up whatever the first operand
	AST_DBL_STEP_FLAG: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		op_valid_in && op_sel_in == OP_SAT_DOUBLE_SUB && second_operand_in == SINT_MIN
		|=> sat_flag_out)
		else $error("doubling clamp did not set the flag");
endmodule : saturating_arith_unit

//--- verif/dest_reg_model.sv
// partner model: register file side taking each written result
`timescale 1ns/1ps
module dest_reg_model (
	// clock
	input  wire logic        clk_in,
	// write-back from the unit
	input  wire logic        wr_in,
	input  wire logic [31:0] data_in,
	// captured destination and write count
	output logic [31:0]      dest_out,
	output int               wr_cnt_out
);
	initial wr_cnt_out = 0;
	// destination is never stack_pointer or program_counter, so every write lands here
	always @(posedge clk_in) if (wr_in === 1'b1) begin
		dest_out <= data_in;
		wr_cnt_out <= wr_cnt_out + 1;
	end
endmodule : dest_reg_model

//--- verif/saturating_arith_unit_tb.sv
// self-checking testbench for the saturating arithmetic unit
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module saturating_arith_unit_tb import sat_arith_pkg::*;;
	localparam longint SMAX = 64'h7FFFFFFF;
	localparam longint SMIN = -SMAX - 1;
	logic        sys_clk_in = 0, rst_in = 1, op_valid_in = 0, status_write_instr_in = 0;
	logic        status_write_q_in = 0, result_valid_out, cond_flags_we_out, sat_flag_out;
	sat_op_t     op_sel_in = OP_NONE;
	logic [31:0] first_operand_in = 0, second_operand_in = 0, result_out, dest, last;
	int          error_cnt = 0, checked = 0, cycles = 0, wr_cnt, n_acc = 0;
	logic        qv, exp_flag;
	always #10 sys_clk_in = ~sys_clk_in;
	saturating_arith_unit saturating_arith_unit_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.op_valid_in(op_valid_in), .op_sel_in(op_sel_in), .first_operand_in(first_operand_in),
		.second_operand_in(second_operand_in), .status_write_instr_in(status_write_instr_in),
		.status_write_q_in(status_write_q_in), .result_valid_out(result_valid_out),
		.result_out(result_out), .cond_flags_we_out(cond_flags_we_out),
		.sat_flag_out(sat_flag_out));
	dest_reg_model dest_reg_model_i (.clk_in(sys_clk_in), .wr_in(result_valid_out),
		.data_in(result_out), .dest_out(dest), .wr_cnt_out(wr_cnt));
	function automatic longint sat(longint v, longint lo, longint hi);
		if (v > hi || v < lo) qv = 1;
		return (v > hi) ? hi : (v < lo) ? lo : v;
	endfunction : sat
	// bench reference: clamps each step, lanes in place except the exchange ops, which swap the halves of b
	function automatic logic [31:0] ref_op(sat_op_t op, logic [31:0] a, logic [31:0] b);
		longint w, m, x, y, r, d;
		logic sb, ex;
		qv = 0;
		if (op inside {OP_SAT_DOUBLE_ADD, OP_SAT_DOUBLE_SUB}) begin
			d = sat(2 * longint'($signed(b)), SMIN, SMAX);
			r = sat(longint'($signed(a)) + ((op == OP_SAT_DOUBLE_ADD) ? d : -d), SMIN, SMAX);
			exp_flag = exp_flag | qv;
			return r[31:0];
		end
		w = (op inside {OP_UNS_SAT_ADD_BYTES, OP_UNS_SAT_SUB_BYTES}) ? 8 : 16;
		m = (64'h1 << w) - 1;
		r = 0;
		ex = op inside {OP_UNS_SAT_ADD_SUB_EXCHANGE, OP_UNS_SAT_SUB_ADD_EXCHANGE};
		for (int i = 0; i < 32 / w; i++) begin
			x = (a >> (i * w)) & m;
			y = (b >> ((ex ? 1 - i : i) * w)) & m;
			sb = op inside {OP_UNS_SAT_SUB_HALVES, OP_UNS_SAT_SUB_BYTES} ||
				(op == OP_UNS_SAT_ADD_SUB_EXCHANGE && i == 0) ||
				(op == OP_UNS_SAT_SUB_ADD_EXCHANGE && i == 1);
			r = r | (sat(sb ? x - y : x + y, 0, m) << (i * w));
		end
		return r[31:0];
	endfunction : ref_op
	// one cycle per call, so calls in a row are back-to-back requests
	task automatic run(sat_op_t op, logic [31:0] a, logic [31:0] b, logic v);
		logic acc;
		acc = v && op != OP_NONE;
		if (acc) begin
			last = ref_op(op, a, b);
			n_acc++;
		end
		op_valid_in = v;
		op_sel_in = op;
		first_operand_in = a;
		second_operand_in = b;
		@(posedge sys_clk_in);
		#1;
		`CHK("valid", acc, result_valid_out)
		`CHK("result", last, result_out)
		`CHK("flag", exp_flag, sat_flag_out)
		`CHK("nzcv we", 1'b0, cond_flags_we_out)
	endtask : run
	task automatic status(logic q);
		status_write_instr_in = 1;
		status_write_q_in = q;
		exp_flag = q;
		run(OP_NONE, 0, 0, 0);
		status_write_instr_in = 0;
	endtask : status
	task automatic t_double;
		run(OP_SAT_DOUBLE_ADD, 0, 32'h7FFFFFFF, 1);
		status(0);
		run(OP_SAT_DOUBLE_ADD, 32'h00000005, 32'h00000003, 1);
		run(OP_SAT_DOUBLE_ADD, 32'h80000000, 32'h40000000, 1);
		status(0);
		run(OP_SAT_DOUBLE_SUB, 0, 32'h80000000, 1);
		run(OP_SAT_DOUBLE_SUB, 32'h0000000A, 32'h00000004, 1);
		// only the final step clamps here
		status(0);
		run(OP_SAT_DOUBLE_SUB, 32'h80000000, 32'h00000001, 1);
		status(1);
		status(0);
		// clear and set in one cycle: set must win
		status_write_instr_in = 1;
		run(OP_SAT_DOUBLE_ADD, 32'h7FFFFFFF, 32'h7FFFFFFF, 1);
		status_write_instr_in = 0;
		$display("test double done");
	endtask : t_double
	task automatic t_lanes;
		sat_op_t     ops[6] = '{OP_UNS_SAT_ADD_SUB_EXCHANGE, OP_UNS_SAT_SUB_ADD_EXCHANGE,
			OP_UNS_SAT_ADD_HALVES, OP_UNS_SAT_ADD_BYTES, OP_UNS_SAT_SUB_HALVES,
			OP_UNS_SAT_SUB_BYTES};
		logic [31:0] pa[3] = '{32'hFF807F01, 32'h00010203, 32'hFFFF0000};
		logic [31:0] pb[3] = '{32'h019080FF, 32'h01020304, 32'h0001FFFF};
		// flag high for the first ops, low for the rest: unsigned ops never touch it
		foreach (ops[k]) begin
			if (k == 3) status(0);
			for (int p = 0; p < 3; p++) run(ops[k], pa[p], pb[p], 1);
		end
		// refused requests drop result_valid_out and leave the result and flag alone
		run(OP_NONE, 32'h12345678, 32'h1, 1);
		run(OP_UNS_SAT_ADD_BYTES, 32'hFFFFFFFF, 32'hFFFFFFFF, 0);
		`CHK("writes", n_acc, wr_cnt)
		`CHK("dest", last, dest)
		$display("test lanes done");
	endtask : t_lanes
	task automatic test_done;
		$display("checked %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done
	// ceiling well above the few dozen cycles the tests need
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 2000) begin
			error_cnt++;
			test_done();
		end
	end
	initial begin
		repeat (4) @(posedge sys_clk_in);
		#1;
		`CHK("rst valid", 1'b0, result_valid_out)
		`CHK("rst flag", RESET_SAT_FLAG, sat_flag_out)
		rst_in = 0;
		exp_flag = RESET_SAT_FLAG;
		last = 0;
		t_double();
		t_lanes();
		test_done();
	end
endmodule : saturating_arith_unit_tb
